// [dis_regs.sv]
// Purpose: Identity and status register bank read over the command port
// Assumes: Commands arrive already deserialised, synchronous to ref_clk_i
// Notes: Off state is modelled by holding arst_n_i low
//
// Behaviour
// - Status bits 7:5 report operating state code
// - Reset state answers every command with zeros
// - Identity bit 4 selects long or short delay
// - Registers reset by power-on; revision and identity read-only by command
// - Revision register holds fixed major and minor
// - Off state loses all register contents
// - Config lock set/clear by commands and events
// - Control lock set/clear in diag, active, safe
// - Auto-restart inhibit set/clear, set on overvoltage
`timescale 1ns/1ns
`default_nettype none
`include "dis_cfg.svh"
module dis_regs #(
    parameter logic [3:0] MAJOR_REVISION_FIELD = 4'h5,
    parameter logic [3:0] MINOR_REVISION_FIELD = 4'h7,
    parameter int LONG_DELAY_CYC = `DIS_LONG_DELAY_CYC,
    parameter int SHORT_DELAY_CYC = `DIS_SHORT_DELAY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] data_i,
    input wire dis_pkg::dis_state_type op_state_i,
    input wire logic delay_sel_i,
    input wire logic selftest_done_i,
    input wire logic regulator_ov_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic [7:0] status_o,
    output logic [31:0] reset_ext_cycles_o
);
    import dis_pkg::*;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    dis_sel_type rd_sel;
    logic set_cfg, clr_cfg, set_ctrl, clr_ctrl, set_inh, clr_inh;

    dis_cmd_decode u_dec (
        .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i),
        .data_i(data_i),
        .rd_sel_o(rd_sel),
        .set_cfg_o(set_cfg),
        .clr_cfg_o(clr_cfg),
        .set_ctrl_o(set_ctrl),
        .clr_ctrl_o(clr_ctrl),
        .set_inh_o(set_inh),
        .clr_inh_o(clr_inh)
    );

    // ----------------------------------------------------------------
    // State tracking
    // ----------------------------------------------------------------
    // Lock bits: 0 control lock, 1 self-test control lock, 2 config lock
    localparam int LOCK_COUNT = 3;

    dis_state_type state_reg;
    logic delay_sel_reg;
    logic [LOCK_COUNT-1:0] lock_reg;
    wire logic [LOCK_COUNT-1:0] lock_next;
    wire logic [LOCK_COUNT-1:0] lock_set_evt;
    wire logic [LOCK_COUNT-1:0] lock_clr_evt;
    logic inh_reg, inh_next;
    logic strap_taken_reg;

    wire logic in_diag = (state_reg == DIS_ST_DIAG);
    wire logic in_run = in_diag || (state_reg == DIS_ST_ACTIVE) || (state_reg == DIS_ST_SAFE);
    wire logic leave_diag = in_diag && (op_state_i != DIS_ST_DIAG);
    wire logic leave_run = in_run && (op_state_i != state_reg);
    wire logic in_reset = (op_state_i == DIS_ST_RESET);

    // Set wins over clear so a lock event is never lost
    function automatic logic set_wins(input logic cur_val, input logic set_in, input logic clr_in);
        set_wins = set_in ? 1'b1 : (clr_in ? 1'b0 : cur_val);
    endfunction

    // ----------------------------------------------------------------
    // Lock and inhibit events
    // ----------------------------------------------------------------
    // Conditions use the registered state: a command is judged by the
    // state it arrived in, even when the state moves on in that cycle
    assign lock_set_evt[0] = (set_ctrl && in_run) || leave_diag || selftest_done_i;
    assign lock_clr_evt[0] = clr_ctrl && in_run;
    assign lock_set_evt[1] = (set_ctrl && in_run) || leave_run || selftest_done_i;
    assign lock_clr_evt[1] = clr_ctrl && in_run;
    assign lock_set_evt[2] = (set_cfg && in_diag) || leave_diag || selftest_done_i;
    assign lock_clr_evt[2] = clr_cfg && in_diag;

    // A disabled port must not move the inhibit latch; overvoltage still sets it
    wire logic inh_set_evt = (set_inh && !in_reset) || regulator_ov_i;
    wire logic inh_clr_evt = clr_inh && !in_reset;

    genvar lock_idx;
    generate
        for (lock_idx = 0; lock_idx < LOCK_COUNT; lock_idx++) begin : g_lock
            assign lock_next[lock_idx] = set_wins(lock_reg[lock_idx], lock_set_evt[lock_idx],
                                                  lock_clr_evt[lock_idx]);
        end
    endgenerate
    assign inh_next = set_wins(inh_reg, inh_set_evt, inh_clr_evt);

    // ----------------------------------------------------------------
    // State and lock registers
    // ----------------------------------------------------------------
    // Power-on reset defines every bit; off state is this reset held
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= DIS_ST_RESET;
        end else begin
            state_reg <= op_state_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_reg <= {LOCK_COUNT{1'b1}};
            inh_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
            inh_reg <= inh_next;
        end
    end

    // Strap caught on the first clock after release, not in reset
    // Read once per power-on: a strap moved later is not seen
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_taken_reg <= 1'b0;
            delay_sel_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            delay_sel_reg <= delay_sel_i;
        end
    end

    // ----------------------------------------------------------------
    // Register images and read response
    // ----------------------------------------------------------------
    wire logic [7:0] rev_img = {MAJOR_REVISION_FIELD, MINOR_REVISION_FIELD};
    wire logic [7:0] id_img = {3'h0, delay_sel_reg, 4'h0};
    wire logic [7:0] stat_img = {state_reg, 1'b0, inh_reg, lock_reg};

    // Only read commands select data; write codes fall to zero
    logic [7:0] rsp_next;
    always_comb begin
        case (rd_sel)
            DIS_SEL_REV: rsp_next = rev_img;
            DIS_SEL_ID: rsp_next = id_img;
            DIS_SEL_STAT: rsp_next = stat_img;
            default: rsp_next = 8'h00;
        endcase
        if (in_reset) begin
            rsp_next = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    wire logic [31:0] delay_cycles = delay_sel_reg ? 32'(SHORT_DELAY_CYC) : 32'(LONG_DELAY_CYC);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            rsp_data_o <= rsp_next;
        end
    end

    // Status trails the image by one cycle, like the response path
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_o <= 8'h07;
            reset_ext_cycles_o <= 32'h0;
        end else begin
            status_o <= stat_img;
            reset_ext_cycles_o <= delay_cycles;
        end
    end
endmodule
`default_nettype wire

// [dis_cfg.svh]
// Purpose: Constants for the identity and status register bank
// Assumes: Included by its bare name after the package
// Notes: Command codes are the read, lock and auto-restart inhibit command bytes of the serial port
`ifndef DIS_CFG_SVH
`define DIS_CFG_SVH

`define DIS_CMD_RD_REV 8'h01
`define DIS_CMD_RD_ID 8'h02
`define DIS_CMD_RD_STAT1 8'h03
`define DIS_CMD_SET_CFG_LOCK 8'h10
`define DIS_CMD_CLEAR_CONFIG_LOCK_CMD 8'h11
`define DIS_CMD_SET_CTRL_LOCK 8'h12
`define DIS_CMD_CLEAR_CONTROL_LOCK_CMD 8'h13
`define DIS_CMD_SET_AUTO_INH 8'h14
`define DIS_CMD_CLR_AUTO_INH 8'h15
`define DIS_DATA_55 8'h55
`define DIS_DATA_AA 8'haa
`define DIS_STATE_MSB 7
`define DIS_STATE_LSB 5
`define DIS_DELAY_SEL_BIT 4
`define DIS_AUTO_INH_BIT 3
`define DIS_CFG_LOCK_BIT 2
`define DIS_SELFTEST_LOCK_BIT 1
`define DIS_CTRL_LOCK_BIT 0
`define DIS_LONG_DELAY_MS 32
`define DIS_SHORT_DELAY_MS 2
`define DIS_CLK_KHZ 100000
`define DIS_LONG_DELAY_CYC (`DIS_LONG_DELAY_MS * `DIS_CLK_KHZ)
`define DIS_SHORT_DELAY_CYC (`DIS_SHORT_DELAY_MS * `DIS_CLK_KHZ)

`endif

// [dis_pkg.sv]
// Purpose: Types for the identity and status register bank
// Assumes: Nothing
// Notes: State codes are the operating state field encodings
package dis_pkg;
    typedef enum logic [2:0] {
        DIS_ST_RESET = 3'h0,
        DIS_ST_DIAG = 3'h1,
        DIS_ST_ACTIVE = 3'h2,
        DIS_ST_SAFE = 3'h4
    } dis_state_type;

    typedef enum logic [1:0] {
        DIS_SEL_NONE = 2'h0,
        DIS_SEL_REV = 2'h1,
        DIS_SEL_ID = 2'h3,
        DIS_SEL_STAT = 2'h2
    } dis_sel_type;
endpackage

// [dis_cmd_decode.sv]
// Purpose: Decodes one command byte and data byte into strobes
// Assumes: Command and data valid together for one cycle
// Notes: Pure combinational decode
`timescale 1ns/1ns
`default_nettype none
`include "dis_cfg.svh"
module dis_cmd_decode (
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] data_i,
    output dis_pkg::dis_sel_type rd_sel_o,
    output logic set_cfg_o,
    output logic clr_cfg_o,
    output logic set_ctrl_o,
    output logic clr_ctrl_o,
    output logic set_inh_o,
    output logic clr_inh_o
);
    import dis_pkg::*;

    function automatic logic hit(input logic [7:0] c, input logic [7:0] code, input logic [7:0] d,
                                 input logic [7:0] want);
        hit = (c == code) && (d == want);
    endfunction

    assign rd_sel_o = !cmd_valid_i ? DIS_SEL_NONE :
                      (cmd_i == `DIS_CMD_RD_REV) ? DIS_SEL_REV :
                      (cmd_i == `DIS_CMD_RD_ID) ? DIS_SEL_ID :
                      (cmd_i == `DIS_CMD_RD_STAT1) ? DIS_SEL_STAT : DIS_SEL_NONE;
    assign set_cfg_o = cmd_valid_i && hit(cmd_i, `DIS_CMD_SET_CFG_LOCK, data_i, `DIS_DATA_55);
    assign clr_cfg_o = cmd_valid_i && hit(cmd_i, `DIS_CMD_CLEAR_CONFIG_LOCK_CMD, data_i, `DIS_DATA_AA);
    assign set_ctrl_o = cmd_valid_i && hit(cmd_i, `DIS_CMD_SET_CTRL_LOCK, data_i, `DIS_DATA_55);
    assign clr_ctrl_o = cmd_valid_i && hit(cmd_i, `DIS_CMD_CLEAR_CONTROL_LOCK_CMD, data_i, `DIS_DATA_AA);
    assign set_inh_o = cmd_valid_i && hit(cmd_i, `DIS_CMD_SET_AUTO_INH, data_i, `DIS_DATA_AA);
    assign clr_inh_o = cmd_valid_i && hit(cmd_i, `DIS_CMD_CLR_AUTO_INH, data_i, `DIS_DATA_55);
endmodule
`default_nettype wire

// [dis_regs_chk.sv]
// Purpose: Port assertions for the identity and status bank
// Assumes: Strap delay_sel_i steady out of reset
// Notes: Bound to dis_regs below
`timescale 1ns/1ns
`default_nettype none
module dis_regs_chk #(
    parameter logic [3:0] MAJOR_REVISION_FIELD = 4'h5,
    parameter logic [3:0] MINOR_REVISION_FIELD = 4'h7,
    parameter int LONG_DELAY_CYC = 32,
    parameter int SHORT_DELAY_CYC = 2
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] data_i,
    input wire dis_pkg::dis_state_type op_state_i,
    input wire logic delay_sel_i,
    input wire logic selftest_done_i,
    input wire logic regulator_ov_i,
    input wire logic rsp_valid_o,
    input wire logic [7:0] rsp_data_o,
    input wire logic [7:0] status_o,
    input wire logic [31:0] reset_ext_cycles_o
);
    import dis_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic rd_ok = cmd_valid_i && op_state_i != DIS_ST_RESET;
    rsp_pulse_a: assert property (rsp_valid_o == $past(cmd_valid_i)) else $error("response strobe off");
    reset_quiet_a: assert property (cmd_valid_i && op_state_i == DIS_ST_RESET |=> rsp_data_o == 8'h00)
        else $error("reset state answered");
    rev_fixed_a: assert property (rd_ok && cmd_i == 8'h01 |=> rsp_data_o == {MAJOR_REVISION_FIELD, MINOR_REVISION_FIELD})
        else $error("revision wrong");
    id_delay_a: assert property (rd_ok && cmd_i == 8'h02 |=> rsp_data_o == {3'h0, delay_sel_i, 4'h0})
        else $error("identity wrong");
    delay_len_a: assert property ($past(arst_n_i, 2) |-> reset_ext_cycles_o ==
        (delay_sel_i ? SHORT_DELAY_CYC : LONG_DELAY_CYC)) else $error("delay length wrong");
    state_field_a: assert property ($past(arst_n_i, 2) |-> status_o[7:5] == $past(op_state_i, 2))
        else $error("state field wrong");
    nonread_zero_a: assert property (cmd_valid_i && !(cmd_i inside {8'h01, 8'h02, 8'h03})
        |=> rsp_data_o == 8'h00 && status_o[4] == 1'b0) else $error("write answered");
    ov_inhibit_a: assert property (regulator_ov_i |=> ##[0:1] status_o[3]) else $error("inhibit not set");
    selftest_lock_a: assert property (selftest_done_i |=> ##[0:1] status_o[2:0] == 3'h7)
        else $error("locks not set");
endmodule
bind dis_regs dis_regs_chk #(.MAJOR_REVISION_FIELD(MAJOR_REVISION_FIELD), .MINOR_REVISION_FIELD(MINOR_REVISION_FIELD), .LONG_DELAY_CYC(LONG_DELAY_CYC),
    .SHORT_DELAY_CYC(SHORT_DELAY_CYC)) chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .data_i(data_i), .op_state_i(op_state_i),
    .delay_sel_i(delay_sel_i), .selftest_done_i(selftest_done_i), .regulator_ov_i(regulator_ov_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .status_o(status_o),
    .reset_ext_cycles_o(reset_ext_cycles_o));
`default_nettype wire

// [dis_host_model.sv]
// Purpose: Host controller issuing one command byte pair per call
// Assumes: Answer stands from the taking edge on, sampled at the next falling edge
// Notes: Idle bytes are inverted so stale values cannot pass
`timescale 1ns/1ns
`default_nettype none
module dis_host_model (
    input wire logic ref_clk_i,
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_data_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_o,
    output logic [7:0] data_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = 8'hff;
        data_o = 8'hff;
    end
    task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r, output logic ok);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b1;
        cmd_o = c;
        data_o = d;
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b0;
        cmd_o = ~c;
        data_o = ~d;
        ok = rsp_valid_i;
        r = rsp_data_i;
    endtask
endmodule
`default_nettype wire

// [dis_regs_bench.sv]
// Purpose: Command sequences against the bank with expected bytes
// Assumes: Long and short delay counts of 32 and 2 cycles
// Notes: Off state is a held reset
`timescale 1ns/1ns
`default_nettype none
module dis_regs_bench;
    import dis_pkg::*;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic delay_sel_i = 1'b1;
    logic selftest_done_i = 1'b0;
    logic regulator_ov_i = 1'b0;
    dis_state_type op_state_i = DIS_ST_RESET;
    logic cmd_valid, rsp_valid;
    logic [7:0] cmd, data, rsp_data, status;
    logic [31:0] cyc;
    int fails = 0;
    int checks_done = 0;
    initial forever #5 ref_clk_i = ~ref_clk_i;
    dis_host_model host (.ref_clk_i(ref_clk_i), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd), .data_o(data));
    dis_regs #(.MAJOR_REVISION_FIELD(4'h5), .MINOR_REVISION_FIELD(4'h7), .LONG_DELAY_CYC(32), .SHORT_DELAY_CYC(2)) dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .data_i(data),
        .op_state_i(op_state_i), .delay_sel_i(delay_sel_i), .selftest_done_i(selftest_done_i),
        .regulator_ov_i(regulator_ov_i), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .status_o(status), .reset_ext_cycles_o(cyc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        logic ok;
        host.xfer(c, d, r, ok);
        chk({31'h0, ok}, 32'h1);
        chk({24'h0, r}, {24'h0, exp});
    endtask
    task automatic go(input dis_state_type s);
        @(negedge ref_clk_i);
        op_state_i = s;
        repeat (3) @(negedge ref_clk_i);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        rd(8'h03, 8'h00, 8'h00);
        rd(8'h14, 8'haa, 8'h00);
        go(DIS_ST_DIAG);
        chk(cyc, 32'h2);
        rd(8'h01, 8'h00, 8'h57);
        rd(8'h02, 8'h00, 8'h10);
        rd(8'h03, 8'h00, 8'h27);
        chk({24'h0, status}, 32'h27);
        rd(8'h11, 8'haa, 8'h00);
        rd(8'h13, 8'haa, 8'h00);
        rd(8'h03, 8'h00, 8'h20);
        rd(8'h10, 8'haa, 8'h00);
        rd(8'h03, 8'h00, 8'h20);
        rd(8'h10, 8'h55, 8'h00);
        rd(8'h12, 8'h55, 8'h00);
        rd(8'h03, 8'h00, 8'h27);
        rd(8'h83, 8'hff, 8'h00);
        rd(8'h01, 8'h00, 8'h57);
        go(DIS_ST_ACTIVE);
        rd(8'h03, 8'h00, 8'h47);
        rd(8'h13, 8'haa, 8'h00);
        rd(8'h11, 8'haa, 8'h00);
        rd(8'h14, 8'haa, 8'h00);
        rd(8'h03, 8'h00, 8'h4c);
        rd(8'h15, 8'h55, 8'h00);
        rd(8'h03, 8'h00, 8'h44);
        regulator_ov_i = 1'b1;
        @(negedge ref_clk_i);
        regulator_ov_i = 1'b0;
        rd(8'h03, 8'h00, 8'h4c);
        go(DIS_ST_SAFE);
        rd(8'h03, 8'h00, 8'h8e);
        selftest_done_i = 1'b1;
        @(negedge ref_clk_i);
        selftest_done_i = 1'b0;
        rd(8'h03, 8'h00, 8'h8f);
        chk({24'h0, status}, 32'h8f);
        arst_n_i = 1'b0;
        delay_sel_i = 1'b0;
        op_state_i = DIS_ST_RESET;
        repeat (3) @(negedge ref_clk_i);
        chk({24'h0, status}, 32'h7);
        chk(cyc, 32'h0);
        arst_n_i = 1'b1;
        go(DIS_ST_DIAG);
        chk(cyc, 32'h20);
        rd(8'h02, 8'h00, 8'h00);
        rd(8'h03, 8'h00, 8'h27);
        tally_and_finish;
    end
endmodule
`default_nettype wire
